// ---- lcdc_control.sv ----
`timescale 1ns/1ps
module lcdc_control
(
	input wire logic mclk,
	input wire logic srst,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [7:0] reg_rdata,
	input wire logic watch_timer_clock,
	output logic [3:0] bias_level_pins_en,
	output logic booster_cap_pin_a_en,
	output logic booster_cap_pin_b_en,
	output logic [5:0] shared_bias_port_pins,
	output logic booster_run,
	output logic booster_connect,
	output logic display_on,
	output logic [3:0] duty_commons,
	output logic [2:0] bias_divisor,
	output logic [2:0] common_index,
	output logic frame_strobe,
	output logic gen_restart,
	output logic [2:0] lcd_mode_reg_out
);
	logic [7:0] lcd_control_reg;
	logic [2:0] lcd_mode_reg;
	logic ctrl_wr;
	logic frame_tick;
	logic [1:0] bias_type;
	logic [2:0] duty_code;
	logic [3:0] commons_next;
	logic [2:0] bias_next;
	logic disp;

	assign ctrl_wr = reg_write && (reg_addr == lcdc_pkg::LCD_CONTROL_ADDR);
	assign bias_type = lcd_control_reg[lcdc_pkg::BIAS_MSB:lcdc_pkg::BIAS_LSB];
	assign duty_code = lcd_control_reg[lcdc_pkg::DUTY_MSB:lcdc_pkg::DUTY_LSB];
	assign disp = lcd_control_reg[lcdc_pkg::DISP_BIT];

	always_ff @(posedge mclk)
	begin
		if (srst)
			lcd_control_reg <= lcdc_pkg::LCD_CONTROL_RESET;
		else if (ctrl_wr)
			lcd_control_reg <= reg_wdata;
	end

	always_ff @(posedge mclk)
	begin
		if (srst)
			lcd_mode_reg <= lcdc_pkg::LCD_MODE_RESET;
		else if (reg_write && (reg_addr == lcdc_pkg::LCD_MODE_ADDR))
			lcd_mode_reg <= reg_wdata[2:0];
	end

	always_ff @(posedge mclk)
	begin
		if (srst)
			reg_rdata <= 8'h0000;
		else if (reg_read && (reg_addr == lcdc_pkg::LCD_CONTROL_ADDR))
			reg_rdata <= lcd_control_reg;
		else if (reg_read && (reg_addr == lcdc_pkg::LCD_MODE_ADDR))
			reg_rdata <= {5'h00, lcd_mode_reg};
		else
			reg_rdata <= 8'h0000;
	end

	always_comb
	begin
		commons_next = lcdc_pkg::DUTY_COMMONS_2;
		bias_next = lcdc_pkg::BIAS_DIV_2;
		if (!duty_code[2])
		begin
			unique case (duty_code[1:0])
				2'h0:
				begin
					commons_next = lcdc_pkg::DUTY_COMMONS_8;
					bias_next = lcdc_pkg::BIAS_DIV_4;
				end
				2'h1:
				begin
					commons_next = lcdc_pkg::DUTY_COMMONS_4;
					bias_next = lcdc_pkg::BIAS_DIV_3;
				end
				2'h2:
				begin
					commons_next = lcdc_pkg::DUTY_COMMONS_3;
					bias_next = lcdc_pkg::BIAS_DIV_3;
				end
				2'h3:
				begin
					commons_next = lcdc_pkg::DUTY_COMMONS_3;
					bias_next = lcdc_pkg::BIAS_DIV_2;
				end
			endcase
		end
	end

	lcdc_frame_div u_div
	(
		.mclk(mclk),
		.srst(srst),
		.clear(ctrl_wr),
		.watch_timer_clock(watch_timer_clock),
		.clk_sel(lcd_control_reg[lcdc_pkg::CLK_SEL_MSB:lcdc_pkg::CLK_SEL_LSB]),
		.frame_tick(frame_tick)
	);

	// Common scan; restarted by every control write
	always_ff @(posedge mclk)
	begin
		if (srst || ctrl_wr)
			common_index <= 3'h0;
		else if (frame_tick && disp)
		begin
			if ({1'b0, common_index} + 4'h1 >= duty_commons)
				common_index <= 3'h0;
			else
				common_index <= common_index + 3'h1;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			frame_strobe <= 1'b0;
			gen_restart <= 1'b0;
		end
		else
		begin
			frame_strobe <= frame_tick && disp;
			gen_restart <= ctrl_wr;
		end
	end

	// Pin ownership follows the stored bias type; display bit gates drive only
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			bias_level_pins_en <= 4'h0;
			booster_cap_pin_a_en <= 1'b0;
			booster_cap_pin_b_en <= 1'b0;
			shared_bias_port_pins <= 6'h00;
			booster_run <= 1'b0;
			booster_connect <= 1'b0;
			display_on <= 1'b0;
			duty_commons <= lcdc_pkg::DUTY_COMMONS_8;
			bias_divisor <= lcdc_pkg::BIAS_DIV_4;
			lcd_mode_reg_out <= lcdc_pkg::LCD_MODE_RESET;
		end
		else
		begin
			bias_level_pins_en <= {4{bias_type != lcdc_pkg::BIAS_NONE}};
			booster_cap_pin_a_en <= bias_type == lcdc_pkg::BIAS_CAP;
			booster_cap_pin_b_en <= bias_type == lcdc_pkg::BIAS_CAP;
			shared_bias_port_pins <= (bias_type == lcdc_pkg::BIAS_CAP)
				? 6'h3f
				: {2'h0, {4{bias_type != lcdc_pkg::BIAS_NONE}}};
			booster_run <= disp && (bias_type == lcdc_pkg::BIAS_CAP);
			booster_connect <= disp && (bias_type == lcdc_pkg::BIAS_CAP);
			display_on <= disp;
			duty_commons <= commons_next;
			bias_divisor <= bias_next;
			lcd_mode_reg_out <= lcd_mode_reg;
		end
	end

	// Restart pulse and scan reset are both visible one edge after the write
	lcd_ctrl_a: assert property (@(posedge mclk) disable iff (srst)
		(reg_write && reg_addr == lcdc_pkg::LCD_CONTROL_ADDR)
		|=> gen_restart && common_index == 3'h0)
		else $error("control write did not restart generation");
	disp_off_a: assert property (@(posedge mclk) disable iff (srst)
		!display_on |-> !booster_run && !booster_connect && !frame_strobe)
		else $error("booster or drive active while display off");
	boost_cap_a: assert property (@(posedge mclk) disable iff (srst)
		booster_run |-> booster_cap_pin_a_en && shared_bias_port_pins == 6'h3f)
		else $error("booster runs without capacitor bias pins");
	res_pins_a: assert property (@(posedge mclk) disable iff (srst)
		$rose(bias_level_pins_en[0]) && !booster_cap_pin_a_en
		|-> shared_bias_port_pins == 6'h0f)
		else $error("resistor bias pin takeover wrong");
	cap_pins_a: assert property (@(posedge mclk) disable iff (srst)
		booster_cap_pin_b_en |-> bias_level_pins_en == 4'hf)
		else $error("capacitor bias without level pins");
	duty_map_a: assert property (@(posedge mclk) disable iff (srst)
		duty_commons == lcdc_pkg::DUTY_COMMONS_8
		|-> bias_divisor == lcdc_pkg::BIAS_DIV_4)
		else $error("eighth duty without quarter bias");
	scan_range_a: assert property (@(posedge mclk) disable iff (srst)
		{1'b0, common_index} < duty_commons || $changed(duty_commons)
		|| $past(ctrl_wr))
		else $error("common index beyond duty");
	none_pins_a: assert property (@(posedge mclk) disable iff (srst)
		bias_level_pins_en == 4'h0 |-> shared_bias_port_pins == 6'h00)
		else $error("plain bias type still claims pins");
endmodule // lcdc_control

// ---- lcdc_pkg.sv ----
package lcdc_pkg;
	localparam logic [7:0] LCD_CONTROL_ADDR = 8'h00f0;
	localparam logic [7:0] LCD_MODE_ADDR = 8'h00f1;
	localparam logic [7:0] LCD_CONTROL_RESET = 8'h0000;
	localparam logic [2:0] LCD_MODE_RESET = 3'h0;
	localparam logic [7:0] LCD_MODE_MASK = 8'h0007;
	localparam int CLK_SEL_MSB = 7;
	localparam int CLK_SEL_LSB = 6;
	localparam int DUTY_MSB = 5;
	localparam int DUTY_LSB = 3;
	localparam int BIAS_MSB = 2;
	localparam int BIAS_LSB = 1;
	localparam int DISP_BIT = 0;
	localparam logic [1:0] BIAS_NONE = 2'h0;
	localparam logic [1:0] BIAS_CAP = 2'h1;
	localparam logic [1:0] BIAS_RES_INT = 2'h2;
	localparam logic [1:0] BIAS_RES_EXT = 2'h3;
	localparam int FRAME_DIV_LOG2_SLOW = 8;
	localparam int FRAME_DIV_LOG2_FAST = 5;
	localparam logic [3:0] DUTY_COMMONS_8 = 4'h8;
	localparam logic [3:0] DUTY_COMMONS_4 = 4'h4;
	localparam logic [3:0] DUTY_COMMONS_3 = 4'h3;
	localparam logic [3:0] DUTY_COMMONS_2 = 4'h2;
	localparam logic [2:0] BIAS_DIV_4 = 3'h4;
	localparam logic [2:0] BIAS_DIV_3 = 3'h3;
	localparam logic [2:0] BIAS_DIV_2 = 3'h2;
	localparam int CLOCK_HZ = 20000000;
	localparam int CAP_SETTLE_US = 1000;
	localparam int CAP_SETTLE_CYCLES = (CAP_SETTLE_US * (CLOCK_HZ / 1000000));
endpackage

// ---- lcdc_frame_div.sv ----
`timescale 1ns/1ps
// Divides watch-timer ticks by 2^(8-sel); clear restarts the count
module lcdc_frame_div
(
	input wire logic mclk,
	input wire logic srst,
	input wire logic clear,
	input wire logic watch_timer_clock,
	input wire logic [1:0] clk_sel,
	output logic frame_tick
);
	logic [7:0] count_reg;
	logic [7:0] limit;

	assign limit = 8'h00ff >> clk_sel;

	always_ff @(posedge mclk)
	begin
		if (srst || clear)
		begin
			count_reg <= 8'h0000;
			frame_tick <= 1'b0;
		end
		else
		begin
			frame_tick <= 1'b0;
			if (watch_timer_clock)
			begin
				if (count_reg >= limit)
				begin
					count_reg <= 8'h0000;
					frame_tick <= 1'b1;
				end
				else
					count_reg <= count_reg + 8'h0001;
			end
		end
	end
endmodule // lcdc_frame_div

// ---- lcdc_panel_model.sv ----
`timescale 1ns/1ps
// Glass model: counts driven frames, flags a scan past the last common
module lcdc_panel_model
(
	input wire logic mclk,
	input wire logic display_on,
	input wire logic frame_strobe,
	input wire logic [2:0] common_index,
	input wire logic [3:0] duty_commons,
	output logic [15:0] frame_count,
	output logic bad_scan
);
	initial frame_count = 16'h0000;
	initial bad_scan = 1'b0;
	always @(posedge mclk)
	begin
		if (frame_strobe && display_on)
			frame_count <= frame_count + 16'h0001;
		if (display_on && ({1'b0, common_index} >= duty_commons))
			bad_scan <= 1'b1;
	end
endmodule // lcdc_panel_model

// ---- lcdc_control_test.sv ----
`timescale 1ns/1ps
module lcdc_control_test;
	logic mclk, srst, reg_write, reg_read, watch_timer_clock;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
	logic [3:0] level_en, duty_commons;
	logic cap_a, cap_b, booster_run, booster_connect, display_on;
	logic [5:0] shared;
	logic [2:0] bias_divisor, common_index, mode_out;
	logic frame_strobe, gen_restart, bad_scan;
	logic [15:0] frame_count, c0;
	int n_mismatch = 0;
	int n_tests = 0;
	lcdc_control u_dut (.mclk(mclk), .srst(srst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
		.reg_rdata(reg_rdata), .watch_timer_clock(watch_timer_clock),
		.bias_level_pins_en(level_en), .booster_cap_pin_a_en(cap_a),
		.booster_cap_pin_b_en(cap_b), .shared_bias_port_pins(shared),
		.booster_run(booster_run), .booster_connect(booster_connect),
		.display_on(display_on), .duty_commons(duty_commons),
		.bias_divisor(bias_divisor), .common_index(common_index),
		.frame_strobe(frame_strobe), .gen_restart(gen_restart),
		.lcd_mode_reg_out(mode_out));
	lcdc_panel_model u_panel (.mclk(mclk), .display_on(display_on),
		.frame_strobe(frame_strobe), .common_index(common_index),
		.duty_commons(duty_commons), .frame_count(frame_count),
		.bad_scan(bad_scan));
	initial
	begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic print_verdict;
		$display("tests=%0d mismatches=%0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(negedge mclk);
		reg_addr = a;
		reg_wdata = v;
		reg_write = 1'b1;
		@(negedge mclk);
		reg_write = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(negedge mclk);
		reg_addr = a;
		reg_read = 1'b1;
		@(negedge mclk);
		reg_read = 1'b0;
		d = reg_rdata;
	endtask
	task automatic ticks(input int n);
		repeat (n)
		begin
			watch_timer_clock = 1'b1;
			@(negedge mclk);
			watch_timer_clock = 1'b0;
			@(negedge mclk);
		end
	endtask
	task automatic t_reset;
		rd(8'h00f0);
		chk(d, 8'h0000);
		chk({4'h0, duty_commons}, 8'h0008);
		chk({5'h00, bias_divisor}, 8'h0004);
		chk({7'h00, display_on}, 8'h0000);
		wr(8'h00f1, 8'h00ff);
		rd(8'h00f1);
		chk(d, 8'h0007);
		chk({5'h00, mode_out}, 8'h0007);
		rd(8'h0055);
		chk(d, 8'h0000);
	endtask
	task automatic t_duty;
		for (int i = 0; i < 8; i++)
		begin
			wr(8'h00f0, 8'(i << 3));
			repeat (2) @(negedge mclk);
			chk({4'h0, duty_commons}, i > 3 ? 8'h2 : i == 0 ? 8'h8 :
				i == 1 ? 8'h4 : 8'h3);
			chk({5'h00, bias_divisor}, i > 2 ? 8'h2 : i == 0 ? 8'h4 :
				8'h3);
		end
	endtask
	task automatic t_bias;
		for (int b = 0; b < 4; b++)
		begin
			wr(8'h00f0, 8'(b << 1));
			repeat (2) @(negedge mclk);
			chk({2'h0, shared}, b == 1 ? 8'h3f : b > 1 ? 8'hf : 8'h0);
			chk({6'h00, cap_a, cap_b}, b == 1 ? 8'h3 : 8'h0);
			chk({4'h0, level_en}, b > 0 ? 8'hf : 8'h0);
			chk({6'h00, booster_run, booster_connect}, 8'h0);
			// Display stays off with no bias pins
			if (b == 0)
				continue;
			if (b == 1)
				repeat (lcdc_pkg::CAP_SETTLE_CYCLES) @(negedge mclk);
			wr(8'h00f0, 8'((b << 1) | 1));
			repeat (2) @(negedge mclk);
			chk({7'h00, display_on}, 8'h1);
			chk({6'h00, booster_run, booster_connect},
				b == 1 ? 8'h3 : 8'h0);
		end
	endtask
	task automatic t_frame;
		for (int s = 0; s < 4; s++)
		begin
			wr(8'h00f0, 8'((s << 6) | 5));
			chk({7'h00, gen_restart}, 8'h1);
			c0 = frame_count;
			ticks(2 << (8 - s));
			repeat (3) @(negedge mclk);
			chk(8'(frame_count - c0), 8'h2);
			chk({5'h00, common_index}, 8'h02);
		end
		// Rewrite mid-count: the partial count must be lost
		wr(8'h00f0, 8'h00c5);
		c0 = frame_count;
		ticks(20);
		wr(8'h00f0, 8'h00c5);
		ticks(20);
		repeat (3) @(negedge mclk);
		chk(8'(frame_count - c0), 8'h0);
		chk({5'h00, common_index}, 8'h00);
		chk({7'h00, bad_scan}, 8'h0);
	endtask
	initial
	begin
		#(60000 * 50);
		n_mismatch++;
		print_verdict();
	end
	initial
	begin
		srst = 1'b1;
		reg_write = 1'b0;
		reg_read = 1'b0;
		reg_addr = 8'h0000;
		reg_wdata = 8'h0000;
		watch_timer_clock = 1'b0;
		repeat (5) @(posedge mclk);
		@(negedge mclk);
		srst = 1'b0;
		t_reset();
		t_duty();
		t_bias();
		t_frame();
		print_verdict();
	end
endmodule // lcdc_control_test
